//--- common/otg_status_pkg.sv
// Contract
// [R1] grounded flag 0 for A, 1 for B
// [R2] link enables bias, waits 50 ms, reads
// [R3] bias off: resistance code 000 to 101
// [R4] resistance code readable in synchronous mode
// [R5] grounded events raised even with bias off
// [R6] open-state changes send alternate-interrupt event
// [R7] grounded/open flags follow pin termination
// [R8] bias enable bit drives internal pull-up
// [R9] grounded status bit 4, open carkit bit 0
// [R10] grounded changes raise events when enabled
// [R11] session-over flag rises below 0.5 V
// [R12] session-over disabled reads 0 when both enables clear
// [R13] session-ok keeps running, only events suppressed
// [R14] every supply comparator readable in status
// [R15] link uses session-ok for request or presence
// [R16] supply comparator disabled, bit 1 reads 0
// [R17] rising and falling edges reported to link
package otg_status_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SRC_W = 5;
    localparam int RID_W = 3;
    localparam int RID_BANDS = 6;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] REG_RISE_EN = 6'h01;
    localparam logic [ADDR_W-1:0] REG_FALL_EN = 6'h02;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h03;
    localparam logic [ADDR_W-1:0] REG_CARKIT_STATUS = 6'h04;
    localparam logic [ADDR_W-1:0] REG_EVENT = 6'h05;
    localparam logic [ADDR_W-1:0] REG_EVENT_MASK = 6'h06;
    localparam logic [ADDR_W-1:0] REG_RID = 6'h07;

    // field positions, shared by enable, status, event and mask registers; BIT_BIAS_EN and BIT_CARKIT_OPEN are control and carkit status bits
    localparam int BIT_IDENT_OPEN = 0;
    localparam int BIT_SUPPLY = 1;
    localparam int BIT_SESSION_OK = 2;
    localparam int BIT_SESSION_OVER = 3;
    localparam int BIT_IDENT_GND = 4;
    localparam int BIT_BIAS_EN = 0;
    localparam int BIT_CARKIT_OPEN = 0;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [SRC_W-1:0] RISE_EN_RST = 5'h1F;
    localparam logic [SRC_W-1:0] FALL_EN_RST = 5'h1F;
    localparam logic [SRC_W-1:0] MASK_RST = 5'h00;

    // resistance codes, index = band 0 ground .. 5 floating
    localparam logic [RID_W-1:0] RID_GROUND = 3'h0;
    localparam logic [RID_W-1:0] RID_75 = 3'h1;
    localparam logic [RID_W-1:0] RID_102K = 3'h2;
    localparam logic [RID_W-1:0] RID_200K = 3'h3;
    localparam logic [RID_W-1:0] RID_440K = 3'h4;
    localparam logic [RID_W-1:0] RID_FLOAT = 3'h5;

    // link-side settle time after setting the bias, kept for reference
    localparam int BIAS_SETTLE_MS = 50;
    localparam int CLK_MHZ = 125;
    localparam longint BIAS_SETTLE_CYCLES = longint'(BIAS_SETTLE_MS) * 1000 * CLK_MHZ;
endpackage

//--- rtl/edge_events.sv
`timescale 1ns/1ps
module edge_events
    import otg_status_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // levels and enables
    input wire logic [SRC_W-1:0] level_in,
    input wire logic [SRC_W-1:0] rise_en_in,
    input wire logic [SRC_W-1:0] fall_en_in,
    // one-cycle edge events
    output logic [SRC_W-1:0] event_out
);
    logic [SRC_W-1:0] prev_r;
    logic [1:0] arm_r;

    // history and upstream levels start at 0; the first two samples after
    // reset would report a false edge for any source already high
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_r <= '0;
            arm_r <= 2'h0;
        end else begin
            prev_r <= level_in;
            arm_r <= {arm_r[0], 1'b1};
        end
    end

    genvar i;
    generate
        for (i = 0; i < SRC_W; i++) begin : g_edge
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    event_out[i] <= 1'b0;
                end else begin
                    event_out[i] <= arm_r[1] &
                                    ((level_in[i] & ~prev_r[i] & rise_en_in[i]) | // R17
                                     (~level_in[i] & prev_r[i] & fall_en_in[i])); // R17
                end
            end
        end
    endgenerate
endmodule

//--- rtl/rid_encoder.sv
`timescale 1ns/1ps
module rid_encoder
    import otg_status_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // converter band, one-hot ground .. floating
    input wire logic [RID_BANDS-1:0] band_in,
    input wire logic bias_en_in,
    // encoded resistance
    output logic [RID_W-1:0] code_out
);
    function automatic logic [RID_W-1:0] band_code(input logic [RID_BANDS-1:0] b);
        logic [RID_W-1:0] c;
        c = RID_FLOAT;
        if (b[0]) c = RID_GROUND;
        else if (b[1]) c = RID_75;
        else if (b[2]) c = RID_102K;
        else if (b[3]) c = RID_200K;
        else if (b[4]) c = RID_440K;
        return c;
    endfunction

    // bias pull-up distorts the measurement, so the last code is held
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            code_out <= RID_FLOAT;
        end else if (!bias_en_in) begin
            code_out <= band_code(band_in); // R3
        end
    end
endmodule

//--- rtl/otg_id_vbus_status_logic.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module otg_id_vbus_status_logic
    import otg_status_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // comparator levels
    input wire logic ident_grounded_cmp_in,
    input wire logic ident_open_cmp_in,
    input wire logic supply_in_range_cmp_in,
    input wire logic session_ok_cmp_in,
    input wire logic session_over_cmp_in,
    input wire logic [RID_BANDS-1:0] rid_band_in,
    input wire logic sync_mode_in,
    // analog controls
    output logic ident_pin_bias_enable_out,
    output logic supply_cmp_enable_out,
    output logic session_over_cmp_enable_out,
    // event toward the link
    output logic rxcmd_event_out,
    output logic rxcmd_alt_int_out,
    // interrupt
    output logic irq_out
);
    logic [DATA_W-1:0] ctrl_r;
    logic [SRC_W-1:0] rise_en_r;
    logic [SRC_W-1:0] fall_en_r;
    logic [SRC_W-1:0] level_r;
    logic [SRC_W-1:0] event_stat_r;
    logic [SRC_W-1:0] mask_r;
    logic [SRC_W-1:0] edge_evt;
    logic [SRC_W-1:0] cmp_on;
    logic [RID_W-1:0] rid_code;
    logic [DATA_W-1:0] rdata_nxt;
    logic wr_ctrl;
    logic wr_event;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    assign wr_ctrl = reg_wr_in & hit(reg_addr_in, REG_CTRL);
    assign wr_event = reg_wr_in & hit(reg_addr_in, REG_EVENT);

    // the supply and session-over comparators count as enabled while either edge enable is set; the others are always on
    always_comb begin
        cmp_on = '1;
        cmp_on[BIT_SUPPLY] = rise_en_r[BIT_SUPPLY] | fall_en_r[BIT_SUPPLY]; // R16
        cmp_on[BIT_SESSION_OVER] = rise_en_r[BIT_SESSION_OVER] | // R12
                                   fall_en_r[BIT_SESSION_OVER];
    end

    // control register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata_in;
        end
    end

    // edge enable registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rise_en_r <= RISE_EN_RST;
            fall_en_r <= FALL_EN_RST;
        end else begin
            if (reg_wr_in && hit(reg_addr_in, REG_RISE_EN)) begin
                rise_en_r <= reg_wdata_in[SRC_W-1:0];
            end
            if (reg_wr_in && hit(reg_addr_in, REG_FALL_EN)) begin
                fall_en_r <= reg_wdata_in[SRC_W-1:0];
            end
        end
    end

    // mask register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_r <= MASK_RST;
        end else if (reg_wr_in && hit(reg_addr_in, REG_EVENT_MASK)) begin
            mask_r <= reg_wdata_in[SRC_W-1:0];
        end
    end

    // live levels; disabled comparators read 0
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_r <= '0;
        end else begin
            level_r[BIT_IDENT_OPEN] <= ident_open_cmp_in; // R7
            level_r[BIT_SUPPLY] <= supply_in_range_cmp_in & cmp_on[BIT_SUPPLY]; // R16
            level_r[BIT_SESSION_OK] <= session_ok_cmp_in; // R13
            level_r[BIT_SESSION_OVER] <= session_over_cmp_in & // R11
                                         cmp_on[BIT_SESSION_OVER]; // R12
            level_r[BIT_IDENT_GND] <= ident_grounded_cmp_in; // R1
        end
    end

    // edges of the grounded level are watched regardless of the bias
    edge_events u_edges (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(level_r),
        .rise_en_in(rise_en_r),
        .fall_en_in(fall_en_r),
        .event_out(edge_evt)
    ); // R5 R10 R13

    rid_encoder u_rid (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .band_in(rid_band_in),
        .bias_en_in(ctrl_r[BIT_BIAS_EN]),
        .code_out(rid_code)
    );

    // link events: any enabled edge requests an rxcmd, enabled open-state edges flag alt_int
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rxcmd_event_out <= 1'b0;
            rxcmd_alt_int_out <= 1'b0;
        end else begin
            rxcmd_event_out <= |edge_evt; // R17 R10 R5
            rxcmd_alt_int_out <= edge_evt[BIT_IDENT_OPEN]; // R6
        end
    end

    // sticky events, write one to clear, a new edge wins over the clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            event_stat_r <= '0;
        end else begin
            event_stat_r <= (event_stat_r & ~(wr_event ? reg_wdata_in[SRC_W-1:0] : '0))
                            | edge_evt;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(event_stat_r & mask_r);
        end
    end

    // analog controls
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ident_pin_bias_enable_out <= 1'b0;
            supply_cmp_enable_out <= 1'b0;
            session_over_cmp_enable_out <= 1'b0;
        end else begin
            ident_pin_bias_enable_out <= ctrl_r[BIT_BIAS_EN]; // R8
            supply_cmp_enable_out <= cmp_on[BIT_SUPPLY]; // R16
            session_over_cmp_enable_out <= cmp_on[BIT_SESSION_OVER]; // R12
        end
    end

    // read decode
    always_comb begin
        rdata_nxt = '0;
        unique case (reg_addr_in)
            REG_CTRL: rdata_nxt = ctrl_r;
            REG_RISE_EN: rdata_nxt[SRC_W-1:0] = rise_en_r;
            REG_FALL_EN: rdata_nxt[SRC_W-1:0] = fall_en_r;
            REG_STATUS: begin
                rdata_nxt[BIT_SUPPLY] = level_r[BIT_SUPPLY]; // R14 R16
                rdata_nxt[BIT_SESSION_OK] = level_r[BIT_SESSION_OK]; // R14 R13
                rdata_nxt[BIT_SESSION_OVER] = level_r[BIT_SESSION_OVER]; // R14 R12
                rdata_nxt[BIT_IDENT_GND] = level_r[BIT_IDENT_GND]; // R9
            end
            REG_CARKIT_STATUS: rdata_nxt[BIT_CARKIT_OPEN] = level_r[BIT_IDENT_OPEN]; // R9
            REG_EVENT: rdata_nxt[SRC_W-1:0] = event_stat_r;
            REG_EVENT_MASK: rdata_nxt[SRC_W-1:0] = mask_r;
            REG_RID: rdata_nxt[RID_W-1:0] = sync_mode_in ? rid_code : '0; // R4
            default: rdata_nxt = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rdata_nxt : '0;
        end
    end
endmodule

//--- tb/otg_status_properties.sv
`timescale 1ns/1ps
module otg_status_properties
    import otg_status_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic ident_grounded_cmp_in,
    input wire logic ident_open_cmp_in,
    input wire logic session_ok_cmp_in,
    input wire logic sync_mode_in,
    input wire logic ident_pin_bias_enable_out,
    input wire logic supply_cmp_enable_out,
    input wire logic session_over_cmp_enable_out,
    input wire logic rxcmd_event_out,
    input wire logic rxcmd_alt_int_out
);
    logic [2:0] cyc_r;
    // masks the start-up edge that comes from level history reset to 0
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cyc_r <= 3'h0;
        end else if (cyc_r != 3'h7) begin
            cyc_r <= cyc_r + 3'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence ctrl_write;
        reg_wr_in && reg_addr_in == REG_CTRL;
    endsequence
    sequence status_read;
        reg_rd_in && reg_addr_in == REG_STATUS;
    endsequence
    bias_follows_a: assert property (ctrl_write ##1 !reg_wr_in |=>
        ident_pin_bias_enable_out == $past(reg_wdata_in[BIT_BIAS_EN], 2))
        else $error("bias output does not follow control write");
    grounded_status_a: assert property (status_read ##0 $stable(ident_grounded_cmp_in) |=>
        reg_rdata_out[BIT_IDENT_GND] == $past(ident_grounded_cmp_in))
        else $error("grounded status bit wrong");
    open_status_a: assert property ((reg_rd_in && reg_addr_in == REG_CARKIT_STATUS)
        ##0 $stable(ident_open_cmp_in) |=> reg_rdata_out[BIT_CARKIT_OPEN] == $past(ident_open_cmp_in))
        else $error("open status bit wrong");
    session_live_a: assert property (status_read ##0 $stable(session_ok_cmp_in) |=>
        reg_rdata_out[BIT_SESSION_OK] == $past(session_ok_cmp_in))
        else $error("session ok status bit wrong");
    supply_off_a: assert property (status_read ##0 !supply_cmp_enable_out
        ##1 !supply_cmp_enable_out |-> !reg_rdata_out[BIT_SUPPLY])
        else $error("disabled supply bit reads one");
    over_off_a: assert property (status_read ##0 !session_over_cmp_enable_out
        ##1 !session_over_cmp_enable_out |-> !reg_rdata_out[BIT_SESSION_OVER])
        else $error("disabled session over bit reads one");
    rid_async_a: assert property ((reg_rd_in && reg_addr_in == REG_RID && !sync_mode_in)
        ##1 !sync_mode_in |-> reg_rdata_out == 8'h00)
        else $error("resistance code visible outside sync mode");
    alt_event_a: assert property (rxcmd_alt_int_out |-> rxcmd_event_out)
        else $error("alternate flag without event");
    alt_cause_a: assert property (rxcmd_alt_int_out && cyc_r == 3'h7 |->
        $past(ident_open_cmp_in, 3) != $past(ident_open_cmp_in, 4))
        else $error("alternate event without open change");
endmodule

//--- tb/link_model.sv
`timescale 1ns/1ps
module link_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // receive command requests
    input wire logic rxcmd_event_in,
    input wire logic rxcmd_alt_int_in,
    // counted commands
    output int evt_count_out,
    output int alt_count_out
);
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            evt_count_out <= 0;
            alt_count_out <= 0;
        end else begin
            evt_count_out <= evt_count_out + int'(rxcmd_event_in);
            alt_count_out <= alt_count_out + int'(rxcmd_alt_int_in);
        end
    end
endmodule

//--- tb/test_otg_id_vbus_status_logic.sv
`timescale 1ns/1ps
module test_otg_id_vbus_status_logic;
    import otg_status_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in = 6'h00;
    logic [DATA_W-1:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic gnd = 1'b0;
    logic open = 1'b0;
    logic supply = 1'b0;
    logic ok = 1'b0;
    logic over = 1'b0;
    logic [RID_BANDS-1:0] band = 6'h00;
    logic sync = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic bias, sup_en, over_en, evt, alt, irq;
    int mismatches = 0;
    int check_count = 0;
    int evt_count, alt_count, e, a;
    always #4 clk_in = ~clk_in;
    otg_id_vbus_status_logic i_otg_id_vbus_status_logic (.clk_in(clk_in), .resetn_in(resetn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .ident_grounded_cmp_in(gnd),
        .ident_open_cmp_in(open), .supply_in_range_cmp_in(supply), .session_ok_cmp_in(ok),
        .session_over_cmp_in(over), .rid_band_in(band), .sync_mode_in(sync),
        .ident_pin_bias_enable_out(bias), .supply_cmp_enable_out(sup_en),
        .session_over_cmp_enable_out(over_en), .rxcmd_event_out(evt),
        .rxcmd_alt_int_out(alt), .irq_out(irq));
    link_model i_link_model (.clk_in(clk_in), .resetn_in(resetn_in), .rxcmd_event_in(evt),
        .rxcmd_alt_int_in(alt), .evt_count_out(evt_count), .alt_count_out(alt_count));
    task check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        wt(1);
    endtask
    task rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] x);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        wt(1);
        reg_rd_in <= 1'b0;
        check(rdata, x);
        wt(1);
    endtask
    task t_regs;
        rd(REG_CTRL, 8'h00);
        rd(REG_RISE_EN, 8'h1F);
        rd(REG_FALL_EN, 8'h1F);
        rd(REG_EVENT_MASK, 8'h00);
        rd(REG_RID, 8'h05);
        rd(6'h3F, 8'h00);
    endtask
    task t_ident;
        wr(REG_CTRL, 8'h01);
        check(8'(bias), 8'h01);
        gnd <= 1'b1;
        open <= 1'b1;
        wt(5);
        rd(REG_STATUS, 8'h10);
        rd(REG_CARKIT_STATUS, 8'h01);
        e = evt_count;
        a = alt_count;
        open <= 1'b0;
        wt(5);
        rd(REG_CARKIT_STATUS, 8'h00);
        check(8'(alt_count - a), 8'h01);
        wr(REG_CTRL, 8'h00);
        gnd <= 1'b0;
        wt(5);
        rd(REG_STATUS, 8'h00);
        check(8'(evt_count - e), 8'h02);
        check(8'(bias), 8'h00);
    endtask
    task t_supply;
        wr(REG_RISE_EN, 8'h15);
        wr(REG_FALL_EN, 8'h15);
        supply <= 1'b1;
        ok <= 1'b1;
        over <= 1'b1;
        wt(5);
        rd(REG_STATUS, 8'h04);
        check(8'({sup_en, over_en}), 8'h00);
        wr(REG_RISE_EN, 8'h11);
        wr(REG_FALL_EN, 8'h11);
        e = evt_count;
        ok <= 1'b0;
        wt(5);
        check(8'(evt_count - e), 8'h00);
        rd(REG_STATUS, 8'h00);
        ok <= 1'b1;
        wt(5);
        check(8'(evt_count - e), 8'h00);
        rd(REG_STATUS, 8'h04);
        ok <= 1'b0;
        wt(5);
        wr(REG_RISE_EN, 8'h1F);
        wr(REG_FALL_EN, 8'h1F);
        wt(3);
        rd(REG_STATUS, 8'h0A);
        check(8'({sup_en, over_en}), 8'h03);
    endtask
    task t_irq;
        wr(REG_EVENT, 8'h1F);
        rd(REG_EVENT, 8'h00);
        wr(REG_EVENT_MASK, 8'h04);
        ok <= 1'b1;
        wt(5);
        rd(REG_EVENT, 8'h04);
        check(8'(irq), 8'h01);
        wr(REG_EVENT_MASK, 8'h00);
        wt(2);
        check(8'(irq), 8'h00);
        wr(REG_EVENT_MASK, 8'h04);
        wt(2);
        check(8'(irq), 8'h01);
        wr(REG_EVENT, 8'h04);
        wt(2);
        check(8'(irq), 8'h00);
    endtask
    task t_rid;
        for (int i = 0; i < RID_BANDS; i++) begin
            band <= 6'h01 << i;
            wt(3);
            rd(REG_RID, 8'(i));
        end
        sync <= 1'b0;
        wt(2);
        rd(REG_RID, 8'h00);
        sync <= 1'b1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_in);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        wt(3);
        t_regs();
        t_ident();
        t_supply();
        t_irq();
        t_rid();
        complete_run();
    end
endmodule
bind otg_id_vbus_status_logic otg_status_properties i_otg_status_properties (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ident_grounded_cmp_in(ident_grounded_cmp_in),
    .ident_open_cmp_in(ident_open_cmp_in), .session_ok_cmp_in(session_ok_cmp_in),
    .sync_mode_in(sync_mode_in), .ident_pin_bias_enable_out(ident_pin_bias_enable_out),
    .supply_cmp_enable_out(supply_cmp_enable_out), .rxcmd_event_out(rxcmd_event_out),
    .session_over_cmp_enable_out(session_over_cmp_enable_out),
    .rxcmd_alt_int_out(rxcmd_alt_int_out));
